// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.vh"
module tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, t1w, t2w, acw, tw, dw;
  logic [3:0] wstrb = 0;
  logic [6:0] we, ef;
  wire awready, wready, bvalid, arready, rvalid, range_on;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [6:0] time_flags;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int num_errors = 0, comparisons = 0, cycles = 0;
  logic [11:0] da[5] = '{`TSC_OFS_T1, `TSC_OFS_T2, `TSC_OFS_ACT, `TSC_OFS_WDAY, `TSC_OFS_CTRL};
  logic [31:0] dv[5] = '{32'h0008_0000, 32'h0011_0000, 32'h010C_0000, 32'h001F, 32'h0001};
  localparam logic [1:0] ERR = `TSC_RESP_SLVERR;

  tsc_time_setpoint_comparator #(.TICK_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .time_flags(time_flags));
  tsc_logic_partner u_eq (.aclk(aclk), .time_flags(time_flags), .range_on(range_on));

  // Clock and hang guard
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bus master: both write channels offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] e);
    logic ad, wd;
    exp_b.push_back(e);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    ad = 0; wd = 0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
      if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 0; end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    araddr <= a; arvalid <= 1; rready <= 1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 0;
    @(posedge aclk);
  endtask

  // Response monitor takes the oldest expectation
  always @(posedge aclk) begin
    if (rvalid && rready) chk("rdata", {rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, exp_b.pop_front()});
  end

  function automatic logic [31:0] hms(input int h, input int m, input int s);
    hms = {11'h0, h[4:0], 2'h0, m[5:0], 2'h0, s[5:0]};
  endfunction

  // Packed fields keep time-of-day order, so one compare serves the timers
  function automatic logic [6:0] flg();
    flg = {tw[5:0] == acw[5:0], tw[13:8] == acw[13:8], tw[20:16] == acw[20:16],
      dw[12:8] == acw[28:24], we[dw[2:0]], tw[20:0] >= t2w[20:0], tw[20:0] >= t1w[20:0]};
  endfunction

  initial begin
    void'($urandom(32'h763a18f5));
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk("rst_flags", {27'h0, time_flags}, 34'h006C);
    for (int i = 0; i < 5; i++) rd(da[i], {2'h0, dv[i]});
    rd(12'h020, {ERR, 32'h0});
    wr(`TSC_OFS_FLAGS, 32'h0, 4'hF, ERR);
    wr(`TSC_OFS_T1, hms(24, 0, 0), 4'hF, ERR);
    wr(`TSC_OFS_T1, hms(9, 60, 0), 4'hF, ERR);
    wr(`TSC_OFS_T1, hms(9, 0, 60), 4'hF, ERR);
    wr(`TSC_OFS_ACT, hms(9, 0, 0), 4'hF, ERR);
    wr(`TSC_OFS_T1, hms(9, 0, 0), 4'h3, ERR);
    rd(`TSC_OFS_T1, {2'h0, 32'h0008_0000});
    // Freeze the calendar so each random setup holds still
    wr(`TSC_OFS_CTRL, 32'h0, 4'hF, 2'h0);
    repeat (12) begin
      tw = hms($urandom % 24, $urandom % 60, $urandom % 60);
      t1w = ($urandom % 2) ? tw : hms($urandom % 24, $urandom % 60, $urandom % 60);
      t2w = hms($urandom % 24, $urandom % 60, $urandom % 60);
      acw = ($urandom % 2) ? tw : hms($urandom % 24, $urandom % 60, $urandom % 60);
      acw[28:24] = 5'(1 + $urandom % 31);
      dw = {19'h0, ($urandom % 2) ? acw[28:24] : 5'(1 + $urandom % 31), 5'h0, 3'($urandom % 7)};
      we = 7'($urandom);
      wr(`TSC_OFS_T1, t1w, 4'hF, 2'h0);
      wr(`TSC_OFS_T2, t2w, 4'hF, 2'h0);
      wr(`TSC_OFS_ACT, acw, 4'hF, 2'h0);
      wr(`TSC_OFS_WDAY, {25'h0, we}, 4'hF, 2'h0);
      wr(`TSC_OFS_TIME, tw, 4'hF, 2'h0);
      wr(`TSC_OFS_DATE, dw, 4'hF, 2'h0);
      ef = flg();
      chk("flags", {27'h0, time_flags}, {27'h0, ef});
      chk("range", {33'h0, range_on}, {33'h0, ef[0] & ~ef[1]});
      rd(`TSC_OFS_FLAGS, {27'h0, ef});
    end
    // Cross midnight on day 31, Sunday: timer drops, date wraps
    wr(`TSC_OFS_T1, hms(23, 59, 59), 4'hF, 2'h0);
    wr(`TSC_OFS_TIME, hms(23, 59, 59), 4'hF, 2'h0);
    wr(`TSC_OFS_DATE, 32'h1F06, 4'hF, 2'h0);
    wr(`TSC_OFS_CTRL, 32'h1, 4'hF, 2'h0);
    while (time_flags[0] !== 1'b0) @(posedge aclk);
    rd(`TSC_OFS_DATE, 34'h0100);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire

// >>> dv/tsc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.vh"
// Bus handshake and flag checks at the comparator's ports
module tsc_chk (
  // Clock and reset
  input wire logic aclk, aresetn,
  // Register bus
  input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid, s_axi_rready,
  // Flags
  input wire logic [6:0] time_flags
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Transfer strobes
  wire aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_go = s_axi_arvalid && s_axi_arready;
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar ready busy");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while busy");
  a_rd_lat: assert property (ar_go |=> s_axi_rvalid) else $error("late read answer");
  // Both channels are held one edge, then the answer rises on the next
  a_wr_lat: assert property (aw_go |-> ##2 s_axi_bvalid) else $error("late write answer");
  a_strb_err: assert property (aw_go && s_axi_wstrb != 4'hF |-> ##2
    s_axi_bresp == `TSC_RESP_SLVERR) else $error("partial strobe accepted");
  a_ro_flags: assert property (aw_go && s_axi_awaddr == `TSC_OFS_FLAGS |-> ##2
    s_axi_bresp == `TSC_RESP_SLVERR) else $error("flag register written");
  a_rd_unmap: assert property (ar_go && s_axi_araddr > `TSC_OFS_CTRL |=>
    s_axi_rresp == `TSC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  // Reset must clear flags even though other checks are off then
  a_rst_flags: assert property (disable iff (1'b0) !aresetn |=> time_flags == 7'h00)
    else $error("flags not cleared");
  c_read: cover property (ar_go);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `TSC_RESP_SLVERR);
  c_midnight: cover property ($fell(time_flags[0]));
endmodule // tsc_chk
bind tsc_time_setpoint_comparator tsc_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_araddr,
  .s_axi_wstrb, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_rresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .time_flags);
`default_nettype wire

// >>> dv/tsc_logic_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Equation engine stand-in: timer one and not timer two makes a daily window
module tsc_logic_partner (
  input wire logic aclk,
  input wire logic [6:0] time_flags,
  output logic range_on
);
  // Registered, as the engine evaluates once per cycle
  always_ff @(posedge aclk) range_on <= time_flags[0] & ~time_flags[1];
endmodule // tsc_logic_partner
`default_nettype wire

// >>> src/tsc_clock_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.vh"

// Calendar counter advanced by a one-second tick, loadable by software
module tsc_clock_counter (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Advance and load
  input wire tick,
  input wire load_time,
  input wire load_date,
  input wire [31:0] load_data,
  // Current time
  output reg [5:0] sec,
  output reg [5:0] min,
  output reg [4:0] hour,
  output reg [2:0] wday,
  output reg [4:0] mday
);

  // Load wins over tick so a write is never overwritten
  always @(posedge aclk) begin
    if (!aresetn) begin
      sec <= `TSC_ZERO6;
      min <= `TSC_ZERO6;
      hour <= 5'h00;
      wday <= 3'h0;
      mday <= `TSC_MDAY_MIN;
    end else if (load_time || load_date) begin
      if (load_time) begin
        sec <= load_data[`TSC_SEC_LSB +: 6];
        min <= load_data[`TSC_MIN_LSB +: 6];
        hour <= load_data[`TSC_HOUR_LSB +: 5];
      end
      if (load_date) begin
        wday <= load_data[`TSC_WDAY_LSB +: 3];
        mday <= load_data[`TSC_MDAY_LSB +: 5];
      end
    end else if (tick) begin
      if (sec != `TSC_SEC_MAX) begin
        sec <= sec + 6'h01;
      end else begin
        sec <= `TSC_ZERO6;
        if (min != `TSC_MIN_MAX) begin
          min <= min + 6'h01;
        end else begin
          min <= `TSC_ZERO6;
          if (hour != `TSC_HOUR_MAX) begin
            hour <= hour + 5'h01;
          end else begin
            // Midnight: no month length table, day wraps after 31
            hour <= 5'h00;
            wday <= (wday == `TSC_WDAY_MAX) ? 3'h0 : wday + 3'h1;
            mday <= (mday == `TSC_MDAY_MAX) ? `TSC_MDAY_MIN : mday + 5'h01;
          end
        end
      end
    end
  end

endmodule // tsc_clock_counter
`default_nettype wire

// >>> src/tsc_defs.vh
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH

// Register byte offsets
`define TSC_OFS_T1 12'h000
`define TSC_OFS_T2 12'h004
`define TSC_OFS_ACT 12'h008
`define TSC_OFS_WDAY 12'h00C
`define TSC_OFS_TIME 12'h010
`define TSC_OFS_DATE 12'h014
`define TSC_OFS_FLAGS 12'h018
`define TSC_OFS_CTRL 12'h01C

// Timer setpoint register fields: sec [5:0], min [13:8], hour [20:16]
`define TSC_SEC_LSB 0
`define TSC_MIN_LSB 8
`define TSC_HOUR_LSB 16
// Active setpoint register: day-of-month in [28:24]
`define TSC_DAY_LSB 24
// Date register: weekday [2:0] (0 = Monday), day-of-month [12:8]
`define TSC_WDAY_LSB 0
`define TSC_MDAY_LSB 8

// Reset values
`define TSC_T1_HOUR_RST 5'h08
`define TSC_T2_HOUR_RST 5'h11
`define TSC_ZERO6 6'h00
`define TSC_ACT_HOUR_RST 5'h0C
`define TSC_ACT_DAY_RST 5'h01
`define TSC_WDAY_EN_RST 7'h1F

// Counter limits
`define TSC_SEC_MAX 6'h3B
`define TSC_MIN_MAX 6'h3B
`define TSC_HOUR_MAX 5'h17
`define TSC_WDAY_MAX 3'h6
`define TSC_MDAY_MAX 5'h1F
`define TSC_MDAY_MIN 5'h01

// Clock rate and one-second tick
`define TSC_CLK_HZ 40000000
`define TSC_TICK_PERIOD_S 1

// AXI responses
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2

`endif

// >>> src/tsc_time_setpoint_comparator.v
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.vh"

module tsc_time_setpoint_comparator #(
  parameter TICK_CYCLES = `TSC_CLK_HZ * `TSC_TICK_PERIOD_S
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Time flags, bit 0 = timer one ... bit 6 = second
  output reg [6:0] time_flags
);

  // Range check shared by all six-bit setpoint fields
  function in_range6;
    input [5:0] v;
    begin
      in_range6 = (v <= `TSC_SEC_MAX);
    end
  endfunction

  // Settings
  reg [5:0] t1_sec, t1_min, t2_sec, t2_min, act_sec, act_min;
  reg [4:0] t1_hour, t2_hour, act_hour, act_day;
  reg [6:0] wday_en;
  reg tick_run;

  // Write channel capture; either channel may arrive first
  reg aw_held, w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_go;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Field decodes of the held write word
  wire [5:0] wr_sec = w_data[`TSC_SEC_LSB +: 6];
  wire [5:0] wr_min = w_data[`TSC_MIN_LSB +: 6];
  wire [4:0] wr_hour = w_data[`TSC_HOUR_LSB +: 5];
  wire [4:0] wr_day = w_data[`TSC_DAY_LSB +: 5];
  wire wr_full = (w_strb == 4'hF);
  // Out of range values are refused whole with SLVERR, so flags never see them
  wire t_ok = in_range6(wr_sec) && in_range6(wr_min) && (wr_hour <= `TSC_HOUR_MAX);
  wire act_ok = t_ok && (wr_day >= `TSC_MDAY_MIN);
  wire date_ok = (w_data[`TSC_WDAY_LSB +: 3] <= `TSC_WDAY_MAX) &&
                 (w_data[`TSC_MDAY_LSB +: 5] >= `TSC_MDAY_MIN);
  reg wr_ok;
  always @* begin
    case (aw_addr)
      `TSC_OFS_T1, `TSC_OFS_T2, `TSC_OFS_TIME: wr_ok = wr_full && t_ok;
      `TSC_OFS_ACT: wr_ok = wr_full && act_ok;
      `TSC_OFS_DATE: wr_ok = wr_full && date_ok;
      `TSC_OFS_WDAY, `TSC_OFS_CTRL: wr_ok = wr_full;
      default: wr_ok = 1'b0;
    endcase
  end
  wire wr_en = wr_go && wr_ok;

  // Setting registers, defaults restored on reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      t1_hour <= `TSC_T1_HOUR_RST;
      t2_hour <= `TSC_T2_HOUR_RST;
      t1_min <= `TSC_ZERO6;
      t2_min <= `TSC_ZERO6;
      t1_sec <= `TSC_ZERO6;
      t2_sec <= `TSC_ZERO6;
      act_day <= `TSC_ACT_DAY_RST;
      act_hour <= `TSC_ACT_HOUR_RST;
      act_min <= `TSC_ZERO6;
      act_sec <= `TSC_ZERO6;
      wday_en <= `TSC_WDAY_EN_RST;
      tick_run <= 1'b1;
    end else if (wr_en) begin
      case (aw_addr)
        `TSC_OFS_T1: begin
          t1_sec <= wr_sec;
          t1_min <= wr_min;
          t1_hour <= wr_hour;
        end
        `TSC_OFS_T2: begin
          t2_sec <= wr_sec;
          t2_min <= wr_min;
          t2_hour <= wr_hour;
        end
        `TSC_OFS_ACT: begin
          act_sec <= wr_sec;
          act_min <= wr_min;
          act_hour <= wr_hour;
          act_day <= wr_day;
        end
        `TSC_OFS_WDAY: wday_en <= w_data[6:0];
        `TSC_OFS_CTRL: tick_run <= w_data[0];
        default: tick_run <= tick_run;
      endcase
    end
  end

  // Write response, one cycle after both channels are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // One-second tick divider; stopping it freezes the calendar for setting
  reg [25:0] div_cnt;
  wire tick = tick_run && (div_cnt == TICK_CYCLES[25:0] - 26'h1);
  always @(posedge aclk) begin
    if (!aresetn || !tick_run || tick) begin
      div_cnt <= 26'h0;
    end else begin
      div_cnt <= div_cnt + 26'h1;
    end
  end

  // Calendar counters
  wire [5:0] cur_sec, cur_min;
  wire [4:0] cur_hour, cur_mday;
  wire [2:0] cur_wday;
  tsc_clock_counter u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .load_time(wr_en && aw_addr == `TSC_OFS_TIME),
    .load_date(wr_en && aw_addr == `TSC_OFS_DATE),
    .load_data(w_data),
    .sec(cur_sec),
    .min(cur_min),
    .hour(cur_hour),
    .wday(cur_wday),
    .mday(cur_mday)
  );

  // Time of day as a single number of seconds for ordered compare
  function [16:0] tod;
    input [4:0] h;
    input [5:0] m;
    input [5:0] s;
    begin
      tod = {12'h000, h} * 17'd3600 + {11'h000, m} * 17'd60 + {11'h000, s};
    end
  endfunction

  wire [16:0] now_tod = tod(cur_hour, cur_min, cur_sec);
  wire [6:0] wday_bit = 7'h01 << cur_wday;

  // Flags follow the counters every cycle, so each tick is re-evaluated
  always @(posedge aclk) begin
    if (!aresetn) begin
      time_flags <= 7'h00;
    end else begin
      // High while tod is at or past set time; midnight resets tod to 0 and clears it unless set at 00:00:00
      time_flags[0] <= now_tod >= tod(t1_hour, t1_min, t1_sec);
      time_flags[1] <= now_tod >= tod(t2_hour, t2_min, t2_sec);
      time_flags[2] <= |(wday_bit & wday_en);
      time_flags[3] <= cur_mday == act_day;
      time_flags[4] <= cur_hour == act_hour;
      time_flags[5] <= cur_min == act_min;
      time_flags[6] <= cur_sec == act_sec;
    end
  end

  // Read path; unmapped addresses answer SLVERR with zero data
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TSC_RESP_OKAY;
      case (s_axi_araddr)
        `TSC_OFS_T1: s_axi_rdata <= {11'h000, t1_hour, 2'h0, t1_min, 2'h0, t1_sec};
        `TSC_OFS_T2: s_axi_rdata <= {11'h000, t2_hour, 2'h0, t2_min, 2'h0, t2_sec};
        `TSC_OFS_ACT: s_axi_rdata <= {3'h0, act_day, 3'h0, act_hour, 2'h0, act_min,
                                      2'h0, act_sec};
        `TSC_OFS_WDAY: s_axi_rdata <= {25'h000_0000, wday_en};
        `TSC_OFS_TIME: s_axi_rdata <= {11'h000, cur_hour, 2'h0, cur_min, 2'h0, cur_sec};
        `TSC_OFS_DATE: s_axi_rdata <= {19'h0_0000, cur_mday, 5'h00, cur_wday};
        `TSC_OFS_FLAGS: s_axi_rdata <= {25'h000_0000, time_flags};
        `TSC_OFS_CTRL: s_axi_rdata <= {31'h0000_0000, tick_run};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TSC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tsc_time_setpoint_comparator
`default_nettype wire
